// >>> verilog/can_ctl0_regs.svh
// register offsets, field positions, reset values, interrupt bits and stamp byte addresses for control register zero
`ifndef CAN_CTL0_REGS_SVH
`define CAN_CTL0_REGS_SVH

`define CTL0_ADDR        12'h000
`define CTL0_IRQ_STAT    12'h004
`define CTL0_IRQ_MASK    12'h008
`define CTL0_ACK_ADDR    12'h00C

`define BIT_FRAME_RX     7
`define BIT_RX_ACTIVE    6
`define BIT_STOP_WAIT    5
`define BIT_BUS_SYNC     4
`define BIT_TIMER_EN     3
`define BIT_WAKE_EN      2
`define BIT_SLEEP_REQ    1
`define BIT_INIT_REQ     0

`define CTL0_RESET       8'h01
`define STAT_RESET       2'h0
`define STAMP_RESET      16'h0000

`define IRQ_FRAME        0
`define IRQ_WAKE         1

`define STAMP_HI_BYTE    4'hF
`define STAMP_LO_BYTE    4'hE

`endif

// >>> verilog/can_ctl0_pkg.sv
// types shared by the control register zero block
`default_nettype none
package can_ctl0_pkg;

  typedef struct packed {
    logic frame_ok;
    logic receiving;
    logic transmitting;
    logic synced;
    logic bit_tick;
    logic acked;
    logic bus_activity;
    logic tx_empty;
  } can_events_type;

  typedef struct packed {
    logic        we;
    logic [3:0]  byte_addr;
    logic [15:0] stamp;
  } stamp_write_type;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_INIT  = 2'b10
  } mode_type;

endpackage : can_ctl0_pkg
`default_nettype wire

// >>> verilog/can_control_zero.sv
// control register zero of the can controller, with apb access and interrupt
// Behaviour
// - set frame flag on every valid received message, whatever the filters (here not while the init request bit is set)
// - frame flag clears only on a written one; zero is ignored
// - frame flag and receiver active carry no meaning in loopback
// - receiver active high while receiving, low while transmitting or idle
// - stop-in-wait set gates the bus interface clock in wait mode
// - bus synchronized status is read only, owned by the device
// - timer enabled runs a 16-bit counter at the bit clock rate
// - on acknowledge, store the stamp into buffer bytes 0x000E and 0x000F
// - counter cleared while disabled; timer enable forced low in init mode
// - wake-up enable lets bus traffic end sleep; set it before sleep
// - init mode holds the register in reset except wake-up enable and the two request bits
// - writes allowed outside init; read-only bits; init request always writable (here it can only be cleared once init acknowledge is set)
// - read data is registered so software never sees it change mid-read
// - sleep entered only when bus idle; then sleep acknowledge set
// - init request aborts traffic, drops sync, then sets init acknowledge (here all three happen on the same edge, one cycle after the request bit)
`include "can_ctl0_regs.svh"
`default_nettype none
module can_control_zero #(
  parameter int STAMP_WIDTH = 16
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [11:0]               paddr_in,
  input  wire logic [31:0]               pwdata_in,
  input  wire logic [3:0]                pstrb_in,
  input  wire can_ctl0_pkg::can_events_type events_in,
  input  wire logic                      loopback_in,
  input  wire logic                      wait_mode_in,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  output logic                           irq_out,
  output logic                           bus_clk_gate_out,
  output logic                           abort_out,
  output logic                           tx_recessive_out,
  output can_ctl0_pkg::stamp_write_type  stamp_out
);
  import can_ctl0_pkg::*;

  logic [7:0]             ctl_q,   ctl_d;
  logic                   init_ack_q, init_ack_d;
  logic                   sleep_ack_q, sleep_ack_d;
  logic [1:0]             stat_q,  stat_d;
  logic [1:0]             mask_q,  mask_d;
  logic [STAMP_WIDTH-1:0] timer_q, timer_d;
  logic [31:0]            rdata_q, rdata_d;
  logic                   ready_q, ready_d;
  logic                   err_q,   err_d;
  logic                   irq_q,   irq_d;
  logic                   gate_q,  gate_d;
  logic                   abort_q, abort_d;
  logic                   rec_q,   rec_d;
  stamp_write_type        stamp_q, stamp_d;
  logic                   stamp_hi_q, stamp_hi_d;
  logic [STAMP_WIDTH-1:0] held_q,  held_d;

  logic in_init;
  logic wr_acc;
  logic rd_acc;
  logic wake_evt;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `CTL0_ADDR) || (a == `CTL0_IRQ_STAT) ||
                (a == `CTL0_IRQ_MASK) || (a == `CTL0_ACK_ADDR);
  endfunction : is_mapped

  // access phase completes in one wait cycle: first access cycle sets ready
  assign wr_acc   = psel_in && penable_in && !ready_q && pwrite_in && pstrb_in[0];
  assign rd_acc   = psel_in && penable_in && !ready_q && !pwrite_in;
  assign in_init  = ctl_q[`BIT_INIT_REQ] && init_ack_q;
  assign wake_evt = sleep_ack_q && ctl_q[`BIT_WAKE_EN] && events_in.bus_activity;

  always_comb begin
    ctl_d       = ctl_q;
    init_ack_d  = init_ack_q;
    sleep_ack_d = sleep_ack_q;
    // software side first; hardware sets below win over clears
    if (wr_acc && paddr_in == `CTL0_ADDR) begin
      if (!in_init) begin
        if (pwdata_in[`BIT_FRAME_RX]) begin
          ctl_d[`BIT_FRAME_RX] = 1'b0;
        end
        ctl_d[`BIT_STOP_WAIT] = pwdata_in[`BIT_STOP_WAIT];
        ctl_d[`BIT_TIMER_EN]  = pwdata_in[`BIT_TIMER_EN];
        ctl_d[`BIT_WAKE_EN]   = pwdata_in[`BIT_WAKE_EN];
        // request bits cannot be dropped before their acknowledge arrives
        if (pwdata_in[`BIT_SLEEP_REQ] || sleep_ack_q) begin
          ctl_d[`BIT_SLEEP_REQ] = pwdata_in[`BIT_SLEEP_REQ];
        end
      end
      if (pwdata_in[`BIT_INIT_REQ] || init_ack_q) begin
        ctl_d[`BIT_INIT_REQ] = pwdata_in[`BIT_INIT_REQ];
      end
    end
    // loopback frames still set the flag; software must disregard it there
    if (events_in.frame_ok && !ctl_d[`BIT_INIT_REQ]) begin
      ctl_d[`BIT_FRAME_RX] = 1'b1;
    end
    ctl_d[`BIT_RX_ACTIVE] = events_in.receiving && !events_in.transmitting && !ctl_q[`BIT_INIT_REQ];
    ctl_d[`BIT_BUS_SYNC]  = events_in.synced && !ctl_q[`BIT_INIT_REQ] && !sleep_ack_q;
    if (wake_evt) begin
      ctl_d[`BIT_SLEEP_REQ] = 1'b0;
      sleep_ack_d = 1'b0;
    end else if (ctl_q[`BIT_SLEEP_REQ] && !ctl_q[`BIT_RX_ACTIVE] && events_in.tx_empty) begin
      sleep_ack_d = 1'b1;
    end else if (!ctl_q[`BIT_SLEEP_REQ]) begin
      sleep_ack_d = 1'b0;
    end
    init_ack_d = ctl_q[`BIT_INIT_REQ];
    if (in_init || ctl_d[`BIT_INIT_REQ] && init_ack_q) begin
      // hold everything except wake-up enable and the two request bits at reset value
      ctl_d = (`CTL0_RESET & 8'hF8) |
              (ctl_d & ((8'h01 << `BIT_WAKE_EN) | (8'h01 << `BIT_SLEEP_REQ) |
                        (8'h01 << `BIT_INIT_REQ)));
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_q       <= `CTL0_RESET;
      init_ack_q  <= 1'b1;
      sleep_ack_q <= 1'b0;
    end else begin
      ctl_q       <= ctl_d;
      init_ack_q  <= init_ack_d;
      sleep_ack_q <= sleep_ack_d;
    end
  end

  // timer and stamp capture
  always_comb begin
    timer_d    = timer_q;
    held_d     = held_q;
    stamp_d    = stamp_q;
    stamp_hi_d = 1'b0;
    stamp_d.we = 1'b0;
    if (!ctl_q[`BIT_TIMER_EN]) begin
      timer_d = '0;
    end else if (events_in.bit_tick) begin
      timer_d = timer_q + STAMP_WIDTH'(1);
    end
    // two byte writes, low byte first, since buffer storage is bytewide
    if (ctl_q[`BIT_TIMER_EN] && events_in.acked) begin
      held_d            = timer_q;
      stamp_d.we        = 1'b1;
      stamp_d.byte_addr = `STAMP_LO_BYTE;
      stamp_d.stamp     = 16'(timer_q);
      stamp_hi_d        = 1'b1;
    end else if (stamp_hi_q) begin
      stamp_d.we        = 1'b1;
      stamp_d.byte_addr = `STAMP_HI_BYTE;
      stamp_d.stamp     = 16'(held_q);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_q    <= `STAMP_RESET;
      held_q     <= `STAMP_RESET;
      stamp_q    <= '0;
      stamp_hi_q <= 1'b0;
    end else begin
      timer_q    <= timer_d;
      held_q     <= held_d;
      stamp_q    <= stamp_d;
      stamp_hi_q <= stamp_hi_d;
    end
  end

  // apb, interrupt and pin side
  always_comb begin
    stat_d  = stat_q;
    mask_d  = mask_q;
    rdata_d = rdata_q;
    ready_d = psel_in && penable_in && !ready_q;
    err_d   = psel_in && penable_in && !ready_q && !is_mapped(paddr_in);
    if (rd_acc) begin
      unique case (paddr_in)
        `CTL0_ADDR:     rdata_d = {24'h000000, ctl_q};
        `CTL0_IRQ_STAT: rdata_d = {30'h00000000, stat_q};
        `CTL0_IRQ_MASK: rdata_d = {30'h00000000, mask_q};
        `CTL0_ACK_ADDR: rdata_d = {30'h00000000, sleep_ack_q, init_ack_q};
        default:        rdata_d = 32'h00000000;
      endcase
      if (paddr_in == `CTL0_IRQ_STAT) begin
        stat_d = `STAT_RESET;
      end
    end
    if (wr_acc && paddr_in == `CTL0_IRQ_MASK) begin
      mask_d = pwdata_in[1:0];
    end
    if (events_in.frame_ok) begin
      stat_d[`IRQ_FRAME] = 1'b1;
    end
    if (wake_evt) begin
      stat_d[`IRQ_WAKE] = 1'b1;
    end
    irq_d   = |(stat_d & mask_d);
    gate_d  = ctl_q[`BIT_STOP_WAIT] && wait_mode_in;
    abort_d = ctl_q[`BIT_INIT_REQ];
    rec_d   = ctl_q[`BIT_INIT_REQ] || gate_d;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q  <= `STAT_RESET;
      mask_q  <= 2'h0;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      irq_q   <= 1'b0;
      gate_q  <= 1'b0;
      abort_q <= 1'b1;
      rec_q   <= 1'b1;
    end else begin
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
      irq_q   <= irq_d;
      gate_q  <= gate_d;
      abort_q <= abort_d;
      rec_q   <= rec_d;
    end
  end

  assign prdata_out       = rdata_q;
  assign pready_out       = ready_q;
  assign pslverr_out      = err_q;
  assign irq_out          = irq_q;
  assign bus_clk_gate_out = gate_q;
  assign abort_out        = abort_q;
  assign tx_recessive_out = rec_q;
  assign stamp_out        = stamp_q;

endmodule : can_control_zero
`default_nettype wire

// >>> test/can_bus_model.sv
// far-side can bus model driving the event struct
`default_nettype none
module can_bus_model (
  input  wire logic                       clk_in,
  output var  can_ctl0_pkg::can_events_type ev_out
);
  import can_ctl0_pkg::*;
  initial ev_out = 8'h01;
  // one-cycle event such as a valid frame, bit tick or ack
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_in) ev_out <= ev_out | m;
    @(posedge clk_in) ev_out <= ev_out & ~m;
  endtask : pulse
  // levels: receiving, synced, bus traffic
  task automatic lvl(input logic [7:0] m, input logic v);
    @(posedge clk_in) ev_out <= v ? (ev_out | m) : (ev_out & ~m);
  endtask : lvl
endmodule : can_bus_model
`default_nettype wire

// >>> test/can_control_zero_assertions.sv
// port assertions for control register zero
`default_nettype none
module can_control_zero_chk #(
  parameter int STAMP_WIDTH = 16
) (
  input wire logic                          ref_clk_in,
  input wire logic                          rst_in,
  input wire logic                          psel_in,
  input wire logic                          penable_in,
  input wire logic                          pwrite_in,
  input wire logic                          wait_mode_in,
  input wire logic [31:0]                   prdata_out,
  input wire logic                          pready_out,
  input wire logic                          pslverr_out,
  input wire logic                          bus_clk_gate_out,
  input wire logic                          abort_out,
  input wire logic                          tx_recessive_out,
  input wire can_ctl0_pkg::stamp_write_type stamp_out
);
  import can_ctl0_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready late");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("error read not zero");
  a_gate_wait: assert property (!wait_mode_in |=> !bus_clk_gate_out)
    else $error("gate outside wait");
  a_stamp_pair: assert property (stamp_out.we && stamp_out.byte_addr == 4'hE |=> stamp_out.we
    && stamp_out.byte_addr == 4'hF && $stable(stamp_out.stamp)) else $error("stamp pair broken");
  a_stamp_order: assert property (stamp_out.we && stamp_out.byte_addr == 4'hF |->
    $past(stamp_out.byte_addr) == 4'hE) else $error("stamp order");
  a_abort_quiet: assert property ($rose(abort_out) |-> tx_recessive_out)
    else $error("abort while not recessive");
endmodule : can_control_zero_chk
bind can_control_zero can_control_zero_chk #(.STAMP_WIDTH(STAMP_WIDTH)) u_chk (.*);
`default_nettype wire

// >>> test/can_control_zero_tb_top.sv
// self-checking bench for control register zero
`include "can_ctl0_regs.svh"
`default_nettype none
module can_control_zero_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import can_ctl0_pkg::*;
  logic            ref_clk_in, rst_in, psel_in, penable_in, pwrite_in, loopback_in, wait_mode_in, e;
  logic            pready_out, pslverr_out, irq_out, bus_clk_gate_out, abort_out, tx_recessive_out;
  logic [11:0]     paddr_in;
  logic [31:0]     pwdata_in, prdata_out, r;
  logic [3:0]      pstrb_in;
  can_events_type  events_in;
  stamp_write_type stamp_out;
  int              bad_count, n_tests, cyc;
  can_control_zero uut (.*);
  can_bus_model bus (.clk_in(ref_clk_in), .ev_out(events_in));
  initial begin
    ref_clk_in = 1'h0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      $display("unexpected at %0t: got %h want %h", $time, g, x);
      bad_count++;
    end
  endtask : chk
  // request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 50);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic t_init;
    rd(`CTL0_ADDR, 32'h01);
    rd(`CTL0_ACK_ADDR, 32'h01);
    apb(1'h1, `CTL0_ADDR, 32'h2B);
    rd(`CTL0_ADDR, 32'h01);
    apb(1'h1, `CTL0_ADDR, 32'h00);
    rd(`CTL0_ACK_ADDR, 32'h00);
  endtask : t_init
  task automatic t_frame;
    apb(1'h1, `CTL0_IRQ_MASK, 32'h01);
    bus.pulse(8'h80);
    rd(`CTL0_ADDR, 32'h80);
    chk(32'(irq_out), 32'h1);
    apb(1'h1, `CTL0_ADDR, 32'h00);
    rd(`CTL0_ADDR, 32'h80);
    apb(1'h1, `CTL0_ADDR, 32'h80);
    rd(`CTL0_ADDR, 32'h00);
    rd(`CTL0_IRQ_STAT, 32'h01);
    rd(`CTL0_IRQ_STAT, 32'h00);
    chk(32'(irq_out), 32'h0);
  endtask : t_frame
  task automatic t_status;
    bus.lvl(8'h50, 1'h1);
    rd(`CTL0_ADDR, 32'h50);
    apb(1'h1, `CTL0_ADDR, 32'h00);
    rd(`CTL0_ADDR, 32'h50);
    bus.lvl(8'h50, 1'h0);
    rd(`CTL0_ADDR, 32'h00);
  endtask : t_status
  // second round proves the count restarted from zero
  task automatic t_stamp;
    int n;
    for (int k = 5; k > 0; k -= 3) begin
      apb(1'h1, `CTL0_ADDR, 32'h08);
      repeat (k) bus.pulse(8'h08);
      bus.pulse(8'h04);
      n = 0;
      while (stamp_out.we !== 1'h1 && n < 20) begin
        @(posedge ref_clk_in);
        n++;
      end
      chk(32'(stamp_out.byte_addr), 32'hE);
      chk(32'(stamp_out.stamp), 32'(k));
      @(posedge ref_clk_in);
      chk(32'(stamp_out.byte_addr), 32'hF);
      apb(1'h1, `CTL0_ADDR, 32'h00);
    end
  endtask : t_stamp
  task automatic t_wait;
    wait_mode_in <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
    chk(32'(bus_clk_gate_out), 32'h0);
    apb(1'h1, `CTL0_ADDR, 32'h20);
    repeat (3) @(posedge ref_clk_in);
    chk(32'(bus_clk_gate_out), 32'h1);
    chk(32'(tx_recessive_out), 32'h1);
    wait_mode_in <= 1'h0;
    repeat (3) @(posedge ref_clk_in);
    chk(32'(bus_clk_gate_out), 32'h0);
    chk(32'(tx_recessive_out), 32'h0);
  endtask : t_wait
  task automatic t_sleep;
    apb(1'h1, `CTL0_ADDR, 32'h06);
    rd(`CTL0_ACK_ADDR, 32'h02);
    bus.lvl(8'h02, 1'h1);
    rd(`CTL0_ACK_ADDR, 32'h00);
    rd(`CTL0_ADDR, 32'h04);
    chk(32'(irq_out), 32'h0);
    rd(`CTL0_IRQ_STAT, 32'h02);
    bus.lvl(8'h02, 1'h0);
  endtask : t_sleep
  task automatic t_err_init;
    apb(1'h0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'h1, `CTL0_ADDR, 32'h01);
    rd(`CTL0_ACK_ADDR, 32'h01);
    chk(32'(abort_out), 32'h1);
    chk(32'(tx_recessive_out), 32'h1);
  endtask : t_err_init
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst_in = 1'h1;
    {psel_in, penable_in, pwrite_in, loopback_in, wait_mode_in} = 5'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    pstrb_in = 4'hF;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    t_init();
    t_frame();
    t_status();
    t_stamp();
    t_wait();
    t_sleep();
    t_err_init();
    tally_and_finish();
  end
  // hang guard, far above the roughly 165 cycles needed
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  end
endmodule : can_control_zero_tb_top
`default_nettype wire
